/* core/cid_fsk_gen.sv */
// Purpose: shared caller-id fsk generator behind a classic wishbone slave
// Assumes: one 25 MHz clock, all inputs synchronous to it
// Notes:   one bit period is BAUD_CYCLES clocks; runs shorter than one bit send one bit
//
// What this block does
// - generator runs only while on/off is one
// - busy reads one, clears when frame sent
// - seizure, mark, then byte plus flag repeated
// - seizure is repeated zero-one bit pairs
// - mark run of ones follows seizure
// - flag run of ones between bytes
// - run lengths come from three length registers
// - seizure bits equal twice programmed value
// - message store is 32 sixteen-bit words
// - byte counter reaching data length ends frame
// - channel select picks the receiving channel
// - standard select picks the tone pair
// - start zero, eight bits lsb first, stop one
// - mark-after-send holds ones until cleared
// - words stored msb first, bytes sent lsb first
// - ram command bit 4 selects message store
// - ram command covers eight consecutive words
`timescale 1ns/100ps
`include "cid_regs.svh"
module cid_fsk_gen
    import cid_pkg::*;
#(
    parameter int BAUD_CYCLES = `CID_BAUD_CYC
)
(
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [5:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output      logic [31:0] DAT_O,
    output      logic        ACK_O,
    output      logic        FSK_BIT,
    output      logic        FSK_TONE,
    output      logic        FSK_ACTIVE,
    output      logic [3:0]  FSK_CH_EN
);
    localparam logic [14:0] TMR_LAST = 15'(BAUD_CYCLES - 1);

    cid_top_t    q;
    cid_top_t    d;
    logic        req;
    logic        wr_ack;
    logic        rd_ack;
    logic [3:0]  idx;
    logic [31:0] rd_val;
    logic [31:0] w;
    logic        set_start;
    logic        tick;
    logic        ram_we;
    logic [15:0] ram_rd_a;
    logic [15:0] ram_rd_b;
    logic [7:0]  tx_byte;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    // -------------------------------------------------------------------------
    // submodules
    // -------------------------------------------------------------------------
    cid_msg_ram u_ram (
        .clk     (CLOCK),
        .rst     (RST),
        .ce      (CE),
        .we      (ram_we),
        .waddr   (q.ptr),
        .wdata   (DAT_I[15:0]),
        .raddr_a (q.ptr),
        .rdata_a (ram_rd_a),
        .raddr_b (q.bcnt[5:1]),
        .rdata_b (ram_rd_b)
    );

    cid_tone_nco u_nco (
        .clk  (CLOCK),
        .rst  (RST),
        .ce   (CE),
        .run  (q.st != ST_IDLE),
        .mark (q.bit_out),
        .std  (q.std),
        .tone (FSK_TONE)
    );

    // -------------------------------------------------------------------------
    // register read view
    // -------------------------------------------------------------------------
    assign idx = ADR_I[5:2];
    // even byte index is the high half: the word is loaded msb first
    assign tx_byte = q.bcnt[0] ? ram_rd_b[7:0] : ram_rd_b[15:8];

    always_comb
    begin
        rd_val = 32'h00000000;
        unique case (idx)
            `CID_IDX_CTRL:
            begin
                rd_val[`CID_CTRL_ON]    = q.on;
                rd_val[`CID_CTRL_START] = q.busy;
                rd_val[`CID_CTRL_STD]   = q.std;
                rd_val[`CID_CTRL_MAS]   = q.mark_after_send;
                rd_val[`CID_CTRL_CH]    = q.ch;
            end
            `CID_IDX_SEIZ:   rd_val[7:0] = q.seiz;
            `CID_IDX_MARK:   rd_val[7:0] = q.mark;
            `CID_IDX_FLAG:   rd_val[7:0] = q.flag;
            `CID_IDX_DLEN:   rd_val[6:0] = q.dlen;
            `CID_IDX_RAMCMD:
            begin
                rd_val[`CID_RAMCMD_FSK] = q.fsk_sel;
                rd_val[`CID_RAMCMD_BLK] = {1'b0, q.ptr[4:3]};
            end
            `CID_IDX_RAMDAT: rd_val[15:0] = q.fsk_sel ? ram_rd_a : 16'h0000;
            `CID_IDX_STATUS: rd_val = {15'h0000, q.bit_out, 2'h0, q.st, 1'h0, q.bcnt};
            default:         rd_val = 32'h00000000;
        endcase
    end

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb
    begin
        d = q;
        req = CYC_I & STB_I;
        // writes land on the edge where the master sees ack
        wr_ack = req & q.ack & WE_I;
        rd_ack = req & q.ack & ~WE_I;
        w = lanes(rd_val, DAT_I, SEL_I);
        set_start = 1'b0;
        ram_we = 1'b0;
        d.ack = req & ~q.ack;
        if (req & ~q.ack)
        begin
            d.dat = rd_val;
        end

        if (wr_ack)
        begin
            unique case (idx)
                `CID_IDX_CTRL:
                begin
                    d.on  = w[`CID_CTRL_ON];
                    d.std = w[`CID_CTRL_STD];
                    d.mark_after_send = w[`CID_CTRL_MAS];
                    d.ch  = w[`CID_CTRL_CH];
                    set_start = SEL_I[0] & DAT_I[`CID_CTRL_START] & w[`CID_CTRL_ON];
                end
                `CID_IDX_SEIZ: d.seiz = w[7:0];
                `CID_IDX_MARK: d.mark = w[7:0];
                `CID_IDX_FLAG: d.flag = w[7:0];
                `CID_IDX_DLEN: d.dlen = w[6:0];
                `CID_IDX_RAMCMD:
                begin
                    d.fsk_sel = w[`CID_RAMCMD_FSK];
                    d.ptr = {w[1:0], 3'h0};
                end
                `CID_IDX_RAMDAT:
                begin
                    ram_we = q.fsk_sel & SEL_I[0] & SEL_I[1];
                end
                default:
                begin
                end
            endcase
        end
        // data port walks the eight words of its block and wraps
        if ((wr_ack | rd_ack) && idx == `CID_IDX_RAMDAT && q.fsk_sel)
        begin
            d.ptr = {q.ptr[4:3], q.ptr[2:0] + 3'h1};
        end

        // one tick per bit period sets the pace of every run
        tick = (q.st != ST_IDLE) && (q.tmr == TMR_LAST);
        d.tmr = tick ? 15'h0000 : q.tmr + 15'h0001;

        if (tick)
        begin
            unique case (q.st)
                ST_SEIZ:
                begin
                    if (q.cnt + 9'h001 >= {q.seiz, 1'b0})
                    begin
                        d.st = ST_MARK;
                        d.cnt = 9'h000;
                        d.bit_out = 1'b1;
                    end
                    else
                    begin
                        d.cnt = q.cnt + 9'h001;
                        d.bit_out = ~q.cnt[0];
                    end
                end
                ST_MARK, ST_FLAG:
                begin
                    if (q.cnt + 9'h001 >= {1'b0, (q.st == ST_MARK) ? q.mark : q.flag})
                    begin
                        d.st = ST_DATA;
                        d.cnt = 9'h000;
                        d.sh = {1'b1, tx_byte, 1'b0};
                        d.bit_out = 1'b0;
                    end
                    else
                    begin
                        d.cnt = q.cnt + 9'h001;
                    end
                end
                ST_DATA:
                begin
                    if (q.cnt == `CID_FRAME_LAST)
                    begin
                        d.bcnt = q.bcnt + 7'h01;
                        d.cnt = 9'h000;
                        d.bit_out = 1'b1;
                        if (q.bcnt + 7'h01 >= q.dlen)
                        begin
                            d.busy = 1'b0;
                            d.st = q.mark_after_send ? ST_HOLD : ST_IDLE;
                        end
                        else
                        begin
                            d.st = ST_FLAG;
                        end
                    end
                    else
                    begin
                        d.cnt = q.cnt + 9'h001;
                        d.sh = {1'b0, q.sh[9:1]};
                        d.bit_out = q.sh[1];
                    end
                end
                default:
                begin
                end
            endcase
        end

        if (q.st == ST_HOLD && !q.mark_after_send)
        begin
            d.st = ST_IDLE;
        end
        if (!q.on)
        begin
            d.st = ST_IDLE;
            d.busy = 1'b0;
        end
        if (d.st == ST_IDLE)
        begin
            d.bit_out = 1'b1;
            d.tmr = 15'h0000;
        end
        // a start in the cycle the frame ends still wins over the clear
        if (set_start)
        begin
            d.busy = 1'b1;
            d.st = ST_SEIZ;
            d.cnt = 9'h000;
            d.bcnt = 7'h00;
            d.tmr = 15'h0000;
            d.bit_out = 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.bit_out <= 1'b1;
            q.seiz <= `CID_RST_SEIZ;
            q.mark <= `CID_RST_MARK;
            q.flag <= `CID_RST_FLAG;
            q.dlen <= `CID_RST_DLEN;
        end
        else if (CE)
        begin
            q <= d;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign DAT_O = q.dat;
    assign ACK_O = q.ack;
    assign FSK_BIT = q.bit_out;
    assign FSK_ACTIVE = q.st != ST_IDLE;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_ch
            assign FSK_CH_EN[g] = (q.st != ST_IDLE) && (q.ch == 3'(g));
        end
    endgenerate

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    sequence s_last_stop;
        CE && tick && q.st == ST_DATA && q.cnt == `CID_FRAME_LAST
            && q.bcnt + 7'h01 >= q.dlen && q.on && !set_start;
    endsequence

    sequence s_start_req;
        CE && set_start;
    endsequence

    property p_off_idle;
        (CE && !q.on && !set_start) |=> (q.st == ST_IDLE && !FSK_ACTIVE && FSK_CH_EN == 4'h0);
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("active while off");

    property p_busy_clear;
        s_last_stop |=> !q.busy;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy kept");

    property p_seiz_to_mark;
        (CE && tick && q.st == ST_SEIZ && q.on && !set_start
            && q.cnt + 9'h001 >= {q.seiz, 1'b0}) |=> (q.st == ST_MARK && FSK_BIT);
    endproperty
    a_seiz_to_mark: assert property (p_seiz_to_mark) else $error("no mark run");

    property p_seiz_pairs;
        q.st == ST_SEIZ |-> FSK_BIT == q.cnt[0];
    endproperty
    a_seiz_pairs: assert property (p_seiz_pairs) else $error("bad seizure bit");

    property p_runs_ones;
        q.st inside {ST_MARK, ST_FLAG, ST_HOLD} |-> FSK_BIT;
    endproperty
    a_runs_ones: assert property (p_runs_ones) else $error("zero in run");

    property p_frame_edges;
        q.st == ST_DATA |-> (q.cnt == 9'h000 ? !FSK_BIT : 1'b1)
            && (q.cnt == `CID_FRAME_LAST ? FSK_BIT : 1'b1);
    endproperty
    a_frame_edges: assert property (p_frame_edges) else $error("bad start/stop");

    property p_start;
        s_start_req |=> (q.st == ST_SEIZ && q.busy && q.cnt == 9'h000 && !FSK_BIT);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_hold;
        (CE && q.st == ST_HOLD && q.mark_after_send && q.on && !set_start) |=> q.st == ST_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("hold dropped");

    property p_one_channel;
        $onehot0(FSK_CH_EN) && (q.ch <= 3'h3 || FSK_CH_EN == 4'h0);
    endproperty
    a_one_channel: assert property (p_one_channel) else $error("channel select");

    property p_ack;
        (CE && CYC_I && STB_I && !ACK_O) |=> ACK_O ##1 (!CE || !ACK_O);
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
endmodule // cid_fsk_gen

/* core/cid_msg_ram.sv */
// Purpose: shared message store, 32 words of 16 bits in flops
// Assumes: one write port, two independent read ports
// Notes:   reads are combinational from the flops
`timescale 1ns/100ps
`include "cid_regs.svh"
module cid_msg_ram
    import cid_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        we,
    input  wire logic [4:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [4:0]  raddr_a,
    output      logic [15:0] rdata_a,
    input  wire logic [4:0]  raddr_b,
    output      logic [15:0] rdata_b
);
    cid_ram_t q;
    cid_ram_t d;

    // -------------------------------------------------------------------------
    // storage
    // -------------------------------------------------------------------------
    always_comb
    begin
        d = q;
        if (we)
        begin
            d.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    assign rdata_a = q.mem[raddr_a];
    assign rdata_b = q.mem[raddr_b];
endmodule // cid_msg_ram

/* core/cid_pkg.sv */
// Purpose: types shared by the caller-id fsk generator
// Assumes: nothing
// Notes:   state structs hold every flop of a module
package cid_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SEIZ = 6'h02,
        ST_MARK = 6'h04,
        ST_DATA = 6'h08,
        ST_FLAG = 6'h10,
        ST_HOLD = 6'h20
    } cid_state_t;

    typedef struct packed {
        logic              ack;
        logic [31:0]       dat;
        logic              on;
        logic              busy;
        logic              std;
        logic              mark_after_send;
        logic [2:0]        ch;
        logic [7:0]        seiz;
        logic [7:0]        mark;
        logic [7:0]        flag;
        logic [6:0]        dlen;
        logic              fsk_sel;
        logic [4:0]        ptr;
        cid_state_t        st;
        logic [8:0]        cnt;
        logic [6:0]        bcnt;
        logic [9:0]        sh;
        logic              bit_out;
        logic [14:0]       tmr;
    } cid_top_t;

    typedef struct packed {
        logic [31:0][15:0] mem;
    } cid_ram_t;

    typedef struct packed {
        logic [23:0]       acc;
    } cid_nco_t;

endpackage

/* core/cid_regs.svh */
// Purpose: register map, field positions, reset values and timing of the caller-id fsk block
// Assumes: 32-bit wishbone data, one register per aligned word, index = byte address / 4
// Notes:   definitions only
`ifndef CID_REGS_SVH
`define CID_REGS_SVH

// -----------------------------------------------------------------------------
// register word indexes
// -----------------------------------------------------------------------------
`define CID_IDX_CTRL    4'h0
`define CID_IDX_SEIZ    4'h1
`define CID_IDX_MARK    4'h2
`define CID_IDX_FLAG    4'h3
`define CID_IDX_DLEN    4'h4
`define CID_IDX_RAMCMD  4'h5
`define CID_IDX_RAMDAT  4'h6
`define CID_IDX_STATUS  4'h7

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define CID_CTRL_ON     0
`define CID_CTRL_START  1
`define CID_CTRL_STD    2
`define CID_CTRL_MAS    3
`define CID_CTRL_CH     6:4
`define CID_RAMCMD_FSK  4
`define CID_RAMCMD_BLK  2:0

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define CID_RST_SEIZ    8'h0F
`define CID_RST_MARK    8'h50
`define CID_RST_FLAG    8'h01
`define CID_RST_DLEN    7'h00

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define CID_CLK_HZ      25000000
`define CID_BAUD        1200
`define CID_BAUD_CYC    (`CID_CLK_HZ / `CID_BAUD)
`define CID_FRAME_LAST  9'h009
`define CID_BELL_MARK   1200
`define CID_BELL_SPACE  2200
`define CID_ALT_MARK    1300
`define CID_ALT_SPACE   2100
`define CID_TONE_INC(f) ((64'(f) * 64'd16777216) / 64'd25000000)

`endif

/* core/cid_tone_nco.sv */
// Purpose: mark/space tone as a square wave from a phase accumulator
// Assumes: 25 MHz clock, 24-bit phase
// Notes:   analogue shaping is left to the channel path
`timescale 1ns/100ps
`include "cid_regs.svh"
module cid_tone_nco
    import cid_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic run,
    input  wire logic mark,
    input  wire logic std,
    output      logic tone
);
    localparam logic [23:0] INC_BM = 24'(`CID_TONE_INC(`CID_BELL_MARK));
    localparam logic [23:0] INC_BS = 24'(`CID_TONE_INC(`CID_BELL_SPACE));
    localparam logic [23:0] INC_AM = 24'(`CID_TONE_INC(`CID_ALT_MARK));
    localparam logic [23:0] INC_AS = 24'(`CID_TONE_INC(`CID_ALT_SPACE));

    cid_nco_t    q;
    cid_nco_t    d;
    logic [23:0] inc;

    // -------------------------------------------------------------------------
    // phase step
    // -------------------------------------------------------------------------
    always_comb
    begin
        // std high picks 1300/2100, low picks 1200/2200
        inc = std ? (mark ? INC_AM : INC_AS) : (mark ? INC_BM : INC_BS);
        d = q;
        d.acc = run ? q.acc + inc : 24'h000000;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    assign tone = q.acc[23];
endmodule // cid_tone_nco

/* dv/cid_fsk_gen_tb.sv */
// Purpose: self-checking bench of the caller-id fsk generator
// Assumes: short bit period, each message fits one store load
// Notes:   line bits are sampled mid-bit, so start latency may vary a few clocks
`timescale 1ns/100ps
module cid_fsk_gen_tb;
    localparam int BC = 8;
    localparam int HP_MARK = 25000000 / (2 * 1300);
    logic        clock;
    logic        rst;
    logic        ce;
    logic        tone;
    logic        t0;
    int          hp;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        fbit;
    logic        act;
    logic [3:0]  chen;
    logic [31:0] q;
    logic [31:0] rnd;
    int          mismatches;
    int          samples_checked;
    logic        exp_q[$];
    logic [7:0]  msg[$];

    cid_fsk_gen #(.BAUD_CYCLES(BC)) cid_fsk_gen_inst (
        .CLOCK(clock), .RST(rst), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
        .FSK_BIT(fbit), .FSK_TONE(tone), .FSK_ACTIVE(act), .FSK_CH_EN(chen));
    cid_host_model host_inst (
        .clk(clock), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .wdat(wdat));

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one message frame: model the line bits, then compare them mid-bit
    task automatic frame(input int ch, input int std, input int mark_after_send, input int n,
                         input int s, input int m, input int f);
        msg.delete();
        exp_q.delete();
        host_inst.xfer(1'b1, 6'h04, 32'(s), q);
        host_inst.xfer(1'b1, 6'h08, 32'(m), q);
        host_inst.xfer(1'b1, 6'h0C, 32'(f), q);
        host_inst.xfer(1'b1, 6'h10, 32'(n), q);
        host_inst.xfer(1'b1, 6'h14, 32'h10, q);
        // one load is enough while the message stays within the eight words of block 0
        for (int w = 0; w < (n + 1) / 2; w++)
        begin
            rnd = lfsr(rnd);
            msg.push_back(rnd[15:8]);
            msg.push_back(rnd[7:0]);
            host_inst.xfer(1'b1, 6'h18, {16'h0, rnd[15:0]}, q);
        end
        for (int i = 0; i < 2 * s; i++) exp_q.push_back(i[0]);
        repeat (m) exp_q.push_back(1'b1);
        for (int b = 0; b < n; b++)
        begin
            exp_q.push_back(1'b0);
            for (int i = 0; i < 8; i++) exp_q.push_back(msg[b][i]);
            exp_q.push_back(1'b1);
            if (b < n - 1) repeat (f) exp_q.push_back(1'b1);
        end
        host_inst.xfer(1'b1, 6'h00, 32'(3 + std * 4 + mark_after_send * 8 + ch * 16), q);
        for (int i = 0; i < 100 && act !== 1'b1; i++) @(posedge clock);
        // a freeze of whole bit periods only delays the line, it must not change it
        if (mark_after_send == 0)
        begin
            ce <= 1'b0;
            repeat (3 * BC) @(posedge clock);
            chk_bit(fbit, 1'b0);
            ce <= 1'b1;
        end
        repeat (BC / 2) @(posedge clock);
        foreach (exp_q[i])
        begin
            chk_bit(fbit, exp_q[i]);
            chk_word({28'h0, chen}, 32'h1 << ch);
            repeat (BC) @(posedge clock);
        end
        host_inst.wait_idle();
        host_inst.xfer(1'b0, 6'h1C, 32'h0, q);
        chk_word({25'h0, q[6:0]}, 32'(n));
        if (mark_after_send != 0)
        begin
            chk_bit(fbit, 1'b1);
            chk_bit(act, 1'b1);
            // hold sends the mark tone; its half period must match the 1300 Hz mark of the alternate pair
            t0 = tone;
            while (tone === t0) @(posedge clock);
            hp = 0;
            while (tone !== t0)
            begin
                hp++;
                @(posedge clock);
            end
            chk_bit(hp > HP_MARK * 985 / 1000 && hp < HP_MARK * 1015 / 1000, 1'b1);
            host_inst.xfer(1'b1, 6'h00, 32'h1, q);
            repeat (3) @(posedge clock);
            chk_bit(act, 1'b0);
        end
    endtask

    // -------------------------------------------------------------------
    // clock, watchdog and main sequence
    // -------------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        mismatches++;
        conclude();
    end

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        rnd = 32'h9100;
        mismatches = 0;
        samples_checked = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        host_inst.xfer(1'b1, 6'h00, 32'h2, q);
        repeat (2) @(posedge clock);
        chk_bit(act, 1'b0);
        chk_bit(tone, 1'b0);
        host_inst.xfer(1'b0, 6'h3C, 32'h0, q);
        chk_word(q, 32'h0);
        frame(2, 0, 0, 3, 1, 2, 1);
        // the store now holds message data, so the select bit is really tested
        host_inst.xfer(1'b1, 6'h14, 32'h10, q);
        host_inst.xfer(1'b0, 6'h18, 32'h0, q);
        chk_word(q, {16'h0, msg[0], msg[1]});
        host_inst.xfer(1'b1, 6'h14, 32'h0, q);
        host_inst.xfer(1'b0, 6'h18, 32'h0, q);
        chk_word(q, 32'h0);
        frame(1, 1, 1, 2, 3, 1, 2);
        host_inst.xfer(1'b1, 6'h00, 32'h0, q);
        conclude();
    end
endmodule // cid_fsk_gen_tb

/* dv/cid_host_model.sv */
// Purpose: host side of the fsk generator, a classic wishbone master
// Assumes: one request at a time, ack sampled on rising edges
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/100ps
module cid_host_model (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output      logic        cyc,
    output      logic        stb,
    output      logic        we,
    output      logic [5:0]  adr,
    output      logic [3:0]  sel,
    output      logic [31:0] wdat
);
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 6'h00;
        sel = 4'h0;
        wdat = 32'h0;
    end

    // -------------------------------------------------------------------
    // bus cycles
    // -------------------------------------------------------------------
    // the leading edge wait keeps cyc low for one cycle between requests
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        adr <= ~a;
        wdat <= ~d;
    endtask

    // no further fsk operation until busy reads zero
    task automatic wait_idle();
        logic [31:0] r;
        do xfer(1'b0, 6'h00, 32'h0, r); while (r[1] !== 1'b0);
    endtask
endmodule // cid_host_model
